// *** core/tfpgm_pkg.sv ***
// Package for the thermal fault and power-good monitor.
// Assumes a 50 MHz system clock and an APB slave with 32-bit data.
package tfpgm_pkg;
  // Command codes; each register sits at byte address 4 * code
  localparam logic [7:0] TFPGM_CMD_OPERATION = 8'h01;
  localparam logic [7:0] TFPGM_CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] TFPGM_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] TFPGM_CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] TFPGM_CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] TFPGM_CMD_OT_FAULT_LIMIT = 8'h4F;
  localparam logic [7:0] TFPGM_CMD_OT_WARN_LIMIT = 8'h51;
  localparam logic [7:0] TFPGM_CMD_POWER_GOOD_ON = 8'h5E;
  localparam logic [7:0] TFPGM_CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] TFPGM_CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] TFPGM_CMD_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] TFPGM_CMD_READ_TEMP = 8'h8D;
  localparam logic [7:0] TFPGM_CMD_MON_CTRL = 8'hD0;
  localparam int TFPGM_IDX_SHIFT = 2;

  // Reset values
  localparam logic [7:0] TFPGM_RST_OPERATION = 8'h80;
  localparam logic [7:0] TFPGM_RST_ON_OFF_CONFIG = 8'h14;
  localparam logic [7:0] TFPGM_RST_ALERT_MASK = 8'h00;
  localparam logic [15:0] TFPGM_RST_VOUT_COMMAND = 16'h019A; // 0.4 V in 1/1024 V
  localparam logic [15:0] TFPGM_RST_OT_FAULT_LIMIT = 16'h007D;
  localparam logic [15:0] TFPGM_RST_OT_WARN_LIMIT = 16'h0069;
  localparam logic [15:0] TFPGM_RST_POWER_GOOD_ON = 16'h0168; // Lands in the 90 % bin of 0.4 V
  localparam logic [7:0] TFPGM_RST_MON_CTRL = 8'h01;

  // Field positions
  localparam int TFPGM_OP_ON_BIT = 7;
  localparam int TFPGM_CFG_CMD_BIT = 3;
  localparam int TFPGM_CFG_PIN_BIT = 2;
  localparam int TFPGM_CTRL_PGMODE_BIT = 0;
  localparam int TFPGM_CTRL_OTLATCH_BIT = 1;
  localparam int TFPGM_ST_OT_FAULT_BIT = 7;
  localparam int TFPGM_ST_OT_WARN_BIT = 6;
  localparam int TFPGM_SB_OFF_BIT = 6;
  localparam int TFPGM_SB_OV_BIT = 5;
  localparam int TFPGM_SB_OC_BIT = 4;
  localparam int TFPGM_SB_TEMP_BIT = 2;
  localparam int TFPGM_SW_PGN_BIT = 11;

  // Thresholds in tenths of a percent and in percent; analog trip point in degrees
  localparam logic [9:0] TFPGM_BIN_A = 10'd796;
  localparam logic [9:0] TFPGM_BIN_B = 10'd851;
  localparam logic [9:0] TFPGM_BIN_C = 10'd898;
  localparam logic [9:0] TFPGM_BIN_D = 10'd951;
  localparam logic [9:0] TFPGM_PERMILLE = 10'd1000;
  localparam logic [6:0] TFPGM_PCT_80 = 7'd80;
  localparam logic [6:0] TFPGM_PCT_85 = 7'd85;
  localparam logic [6:0] TFPGM_PCT_90 = 7'd90;
  localparam logic [6:0] TFPGM_PCT_95 = 7'd95;
  localparam logic [6:0] TFPGM_PCT_HYST = 7'd5;
  localparam logic [6:0] TFPGM_PCT_WIN_LO = 7'd98;
  localparam logic [6:0] TFPGM_PCT_WIN_HI = 7'd102;
  localparam logic [6:0] TFPGM_PCT_FULL = 7'd100;
  localparam logic signed [15:0] TFPGM_ANALOG_TRIP_C = 16'sd145;

  // Power-good state machine
  typedef enum logic [3:0] {
    TFPGM_PG_OFF = 4'b0001,
    TFPGM_PG_RAMP = 4'b0010,
    TFPGM_PG_GOOD = 4'b0100,
    TFPGM_PG_DROP = 4'b1000
  } tfpgm_pg_t;

  // Analog sense and fault inputs
  typedef struct packed {
    logic en;
    logic vcc_ok;
    logic oc_fault;
    logic ov_fault;
    logic analog_ot;
    logic [15:0] fb;
    logic [15:0] temp;
  } tfpgm_sense_t;

  // Whole state of the monitor
  typedef struct packed {
    logic [7:0] operation_r;
    logic [7:0] onoff_cfg_r;
    logic [7:0] alert_mask_r;
    logic [15:0] vout_cmd_r;
    logic [15:0] ot_fault_lim_r;
    logic [15:0] ot_warn_lim_r;
    logic [15:0] pg_on_r;
    logic [7:0] ctrl_r;
    logic [7:0] stat_temp_r;
    logic oc_seen_r;
    logic ov_seen_r;
    logic ot_latched_r;
    logic en_d_r;
    tfpgm_pg_t pg_st_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
  } tfpgm_state_t;
endpackage : tfpgm_pkg

// *** core/tfpgm_monitor.sv ***
// Thermal fault and power-good monitor with an APB register slave.
// Assumes synchronous sense inputs, feedback and setpoint in 1/1024 V,
// temperature in whole degrees (signed), and a zero-wait APB master.
//
// The APB register port and the placing of the registers were chosen for this implementation.
module tfpgm_monitor
  import tfpgm_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Analog sensing and faults
  input wire logic EN_I,
  input wire logic VCC_OK_I,
  input wire logic OVERCURRENT_PROTECTION_I,
  input wire logic OV_FAULT_I,
  input wire logic ANALOG_OT_I,
  input wire logic [15:0] FEEDBACK_SENSE_PIN_I,
  input wire logic [15:0] TEMP_I,
  // Power stage and host signals
  output logic POWER_GOOD_OUTPUT_O,
  output logic SS_PULL_LOW_O,
  output logic CONVERT_EN_O,
  output logic ALERT_LINE_N_O
);

  tfpgm_state_t s_r;
  tfpgm_state_t s_nxt;
  tfpgm_sense_t sn;
  logic [6:0] pg_pct;
  logic powered;
  logic dig_ot;
  logic ot_trip;
  logic warn_trip;
  logic fault_any;
  logic above_upper;
  logic below_lower;
  logic in_window;
  logic [7:0] status_byte;
  logic [15:0] status_word;
  logic [7:0] alert_src;
  logic wr_acc;
  logic rd_setup;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;

  // Register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [11:0] addr);
    reg_idx = addr[TFPGM_IDX_SHIFT +: 8];
  endfunction : reg_idx

  // Setpoint scaled by a percentage, in 1/1024 V times 100
  function automatic logic [22:0] scale_pct(input logic [15:0] v, input logic [6:0] p);
    scale_pct = 23'(v) * 23'(p);
  endfunction : scale_pct

  // Setpoint scaled by tenths of a percent
  function automatic logic [25:0] scale_pm(input logic [15:0] v, input logic [9:0] p);
    scale_pm = 26'(v) * 26'(p);
  endfunction : scale_pm

  // Address known to the map
  function automatic logic reg_known(input logic [7:0] idx);
    unique case (idx)
      TFPGM_CMD_OPERATION, TFPGM_CMD_ON_OFF_CONFIG, TFPGM_CMD_CLEAR_FAULTS,
      TFPGM_CMD_ALERT_MASK, TFPGM_CMD_VOUT_COMMAND, TFPGM_CMD_OT_FAULT_LIMIT,
      TFPGM_CMD_OT_WARN_LIMIT, TFPGM_CMD_POWER_GOOD_ON, TFPGM_CMD_STATUS_BYTE,
      TFPGM_CMD_STATUS_WORD, TFPGM_CMD_STATUS_TEMP, TFPGM_CMD_READ_TEMP,
      TFPGM_CMD_MON_CTRL: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction : reg_known

  // Gather sense inputs
  assign sn = '{en: EN_I, vcc_ok: VCC_OK_I, oc_fault: OVERCURRENT_PROTECTION_I,
                ov_fault: OV_FAULT_I, analog_ot: ANALOG_OT_I,
                fb: FEEDBACK_SENSE_PIN_I, temp: TEMP_I};

  // Quantise the requested threshold to one of four settings
  always_comb begin
    logic [25:0] req;
    req = 26'(s_r.pg_on_r) * 26'(TFPGM_PERMILLE);
    if (!s_r.ctrl_r[TFPGM_CTRL_PGMODE_BIT]) begin
      pg_pct = TFPGM_PCT_90; // Fixed default when not programmable
    end else if (req <= scale_pm(s_r.vout_cmd_r, TFPGM_BIN_A)) begin
      pg_pct = TFPGM_PCT_80;
    end else if (req <= scale_pm(s_r.vout_cmd_r, TFPGM_BIN_B)) begin
      pg_pct = TFPGM_PCT_85;
    end else if (req <= scale_pm(s_r.vout_cmd_r, TFPGM_BIN_C)) begin
      pg_pct = TFPGM_PCT_90;
    end else if (req <= scale_pm(s_r.vout_cmd_r, TFPGM_BIN_D)) begin
      pg_pct = TFPGM_PCT_95;
    end else begin
      pg_pct = TFPGM_PCT_80;
    end
  end

  // Feedback comparisons against the quantised thresholds and the fixed start-up window
  always_comb begin
    logic [22:0] fb100;
    fb100 = scale_pct(sn.fb, TFPGM_PCT_FULL);
    above_upper = fb100 > scale_pct(s_r.vout_cmd_r, pg_pct);
    below_lower = fb100 < scale_pct(s_r.vout_cmd_r, pg_pct - TFPGM_PCT_HYST);
    in_window = (fb100 >= scale_pct(s_r.vout_cmd_r, TFPGM_PCT_WIN_LO)) &&
                (fb100 <= scale_pct(s_r.vout_cmd_r, TFPGM_PCT_WIN_HI));
  end

  // Temperature comparisons and run conditions
  always_comb begin
    dig_ot = ($signed(s_r.ot_fault_lim_r) < TFPGM_ANALOG_TRIP_C) &&
             ($signed(sn.temp) > $signed(s_r.ot_fault_lim_r));
    ot_trip = dig_ot || sn.analog_ot;
    warn_trip = $signed(sn.temp) > $signed(s_r.ot_warn_lim_r);
    powered = sn.vcc_ok && !s_r.ot_latched_r &&
              (!s_r.onoff_cfg_r[TFPGM_CFG_PIN_BIT] || sn.en) &&
              (!s_r.onoff_cfg_r[TFPGM_CFG_CMD_BIT] ||
               s_r.operation_r[TFPGM_OP_ON_BIT]);
    fault_any = sn.oc_fault || sn.ov_fault || ot_trip || s_r.ot_latched_r;
  end

  // Status summaries and alert sources
  always_comb begin
    status_byte = '0;
    status_byte[TFPGM_SB_OFF_BIT] = !powered;
    status_byte[TFPGM_SB_OV_BIT] = s_r.ov_seen_r;
    status_byte[TFPGM_SB_OC_BIT] = s_r.oc_seen_r;
    status_byte[TFPGM_SB_TEMP_BIT] = |s_r.stat_temp_r;
    status_word = {8'h00, status_byte};
    status_word[TFPGM_SW_PGN_BIT] = !(s_r.pg_st_r == TFPGM_PG_GOOD);
    alert_src = s_r.stat_temp_r;
    alert_src[TFPGM_SB_OV_BIT] = s_r.ov_seen_r;
    alert_src[TFPGM_SB_OC_BIT] = s_r.oc_seen_r;
  end

  // APB decode
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
  assign rd_setup = PSEL_I && !PENABLE_I && CE_I;
  assign wr_idx = reg_idx(PADDR_I);
  assign rd_idx = reg_idx(PADDR_I);

  // Next state of the whole monitor
  always_comb begin
    logic clear_faults;
    logic en_fall;
    s_nxt = s_r;
    clear_faults = 1'b0;
    en_fall = s_r.en_d_r && !sn.en;
    s_nxt.en_d_r = sn.en;
    // Register writes take effect in the access phase
    if (wr_acc && reg_known(wr_idx)) begin
      unique case (wr_idx)
        TFPGM_CMD_OPERATION: s_nxt.operation_r = PWDATA_I[7:0];
        TFPGM_CMD_ON_OFF_CONFIG: s_nxt.onoff_cfg_r = PWDATA_I[7:0];
        TFPGM_CMD_CLEAR_FAULTS: clear_faults = 1'b1;
        TFPGM_CMD_ALERT_MASK: s_nxt.alert_mask_r = PWDATA_I[7:0];
        TFPGM_CMD_VOUT_COMMAND: s_nxt.vout_cmd_r = PWDATA_I[15:0];
        TFPGM_CMD_OT_FAULT_LIMIT: s_nxt.ot_fault_lim_r = PWDATA_I[15:0];
        TFPGM_CMD_OT_WARN_LIMIT: s_nxt.ot_warn_lim_r = PWDATA_I[15:0];
        TFPGM_CMD_POWER_GOOD_ON: s_nxt.pg_on_r = PWDATA_I[15:0];
        TFPGM_CMD_MON_CTRL: s_nxt.ctrl_r = PWDATA_I[7:0];
        default: ; // Status and telemetry are read-only
      endcase
    end
    // Latched shutdown ends on enable toggle or operation write
    if (en_fall || (wr_acc && wr_idx == TFPGM_CMD_OPERATION)) begin
      s_nxt.ot_latched_r = 1'b0;
    end
    // Sticky status: clear first so a same-cycle event wins
    if (clear_faults) begin
      s_nxt.stat_temp_r = '0;
      s_nxt.oc_seen_r = 1'b0;
      s_nxt.ov_seen_r = 1'b0;
    end
    if (ot_trip) begin
      s_nxt.stat_temp_r[TFPGM_ST_OT_FAULT_BIT] = 1'b1;
      if (s_r.ctrl_r[TFPGM_CTRL_OTLATCH_BIT]) begin
        s_nxt.ot_latched_r = 1'b1;
      end
    end
    if (warn_trip) begin
      s_nxt.stat_temp_r[TFPGM_ST_OT_WARN_BIT] = 1'b1;
    end
    if (sn.oc_fault) begin
      s_nxt.oc_seen_r = 1'b1;
    end
    if (sn.ov_fault) begin
      s_nxt.ov_seen_r = 1'b1;
    end
    // Power-good sequence
    if (!powered || fault_any) begin
      s_nxt.pg_st_r = (!powered) ? TFPGM_PG_OFF : TFPGM_PG_DROP;
    end else begin
      unique case (s_r.pg_st_r)
        TFPGM_PG_OFF: s_nxt.pg_st_r = TFPGM_PG_RAMP;
        TFPGM_PG_RAMP: begin
          if (s_r.ctrl_r[TFPGM_CTRL_PGMODE_BIT] ? above_upper : in_window) begin
            s_nxt.pg_st_r = TFPGM_PG_GOOD;
          end
        end
        TFPGM_PG_GOOD: begin
          if (below_lower) begin
            s_nxt.pg_st_r = TFPGM_PG_DROP;
          end
        end
        TFPGM_PG_DROP: begin
          if (above_upper) begin
            s_nxt.pg_st_r = TFPGM_PG_GOOD;
          end
        end
        default: s_nxt.pg_st_r = TFPGM_PG_OFF;
      endcase
    end
    // Read data captured in the setup phase
    if (rd_setup) begin
      s_nxt.pslverr_r = !reg_known(rd_idx);
      unique case (rd_idx)
        TFPGM_CMD_OPERATION: s_nxt.prdata_r = 32'(s_r.operation_r);
        TFPGM_CMD_ON_OFF_CONFIG: s_nxt.prdata_r = 32'(s_r.onoff_cfg_r);
        TFPGM_CMD_ALERT_MASK: s_nxt.prdata_r = 32'(s_r.alert_mask_r);
        TFPGM_CMD_VOUT_COMMAND: s_nxt.prdata_r = 32'(s_r.vout_cmd_r);
        TFPGM_CMD_OT_FAULT_LIMIT: s_nxt.prdata_r = 32'(s_r.ot_fault_lim_r);
        TFPGM_CMD_OT_WARN_LIMIT: s_nxt.prdata_r = 32'(s_r.ot_warn_lim_r);
        TFPGM_CMD_POWER_GOOD_ON: s_nxt.prdata_r = 32'(s_r.pg_on_r);
        TFPGM_CMD_STATUS_BYTE: s_nxt.prdata_r = 32'(status_byte);
        TFPGM_CMD_STATUS_WORD: s_nxt.prdata_r = 32'(status_word);
        TFPGM_CMD_STATUS_TEMP: s_nxt.prdata_r = 32'(s_r.stat_temp_r);
        TFPGM_CMD_READ_TEMP: s_nxt.prdata_r = 32'(sn.temp);
        TFPGM_CMD_MON_CTRL: s_nxt.prdata_r = 32'(s_r.ctrl_r);
        default: s_nxt.prdata_r = '0;
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_r <= '{operation_r: TFPGM_RST_OPERATION, onoff_cfg_r: TFPGM_RST_ON_OFF_CONFIG,
               alert_mask_r: TFPGM_RST_ALERT_MASK, vout_cmd_r: TFPGM_RST_VOUT_COMMAND,
               ot_fault_lim_r: TFPGM_RST_OT_FAULT_LIMIT,
               ot_warn_lim_r: TFPGM_RST_OT_WARN_LIMIT, pg_on_r: TFPGM_RST_POWER_GOOD_ON,
               ctrl_r: TFPGM_RST_MON_CTRL, stat_temp_r: 8'h00, oc_seen_r: 1'b0,
               ov_seen_r: 1'b0, ot_latched_r: 1'b0, en_d_r: 1'b0,
               pg_st_r: TFPGM_PG_OFF, prdata_r: 32'h0000_0000, pslverr_r: 1'b0};
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // Outputs; over-current gates power-good and soft-start at once
  assign PRDATA_O = s_r.prdata_r;
  assign PREADY_O = CE_I;
  assign PSLVERR_O = s_r.pslverr_r && PSEL_I && PENABLE_I;
  assign POWER_GOOD_OUTPUT_O = (s_r.pg_st_r == TFPGM_PG_GOOD) && !fault_any;
  assign SS_PULL_LOW_O = sn.oc_fault || !powered;
  assign CONVERT_EN_O = powered && !sn.ov_fault;
  assign ALERT_LINE_N_O = !(|(alert_src & ~s_r.alert_mask_r));

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  // Over-temperature response and recovery
  AST_OT_LATCH: assert property (CE_I && dig_ot && s_r.ctrl_r[TFPGM_CTRL_OTLATCH_BIT]
      |=> s_r.ot_latched_r && !CONVERT_EN_O)
    else $error("OT fault did not latch shutdown");
  AST_OT_NOLATCH: assert property (!s_r.ot_latched_r
      && !s_r.ctrl_r[TFPGM_CTRL_OTLATCH_BIT] && CE_I |=> !s_r.ot_latched_r)
    else $error("OT latched while response is keep converting");
  AST_OT_RECOVER: assert property (CE_I && s_r.ot_latched_r && $fell(EN_I) && !ot_trip
      |=> !s_r.ot_latched_r)
    else $error("Enable toggle did not clear latched shutdown");
  AST_OP_RECOVER: assert property (CE_I && s_r.ot_latched_r && !ot_trip
      && wr_acc && wr_idx == TFPGM_CMD_OPERATION |=> !s_r.ot_latched_r)
    else $error("Operation write did not clear latched shutdown");
  // Warning alarm; a mask written in the same cycle may hide it legally
  AST_WARN_ALERT: assert property (CE_I && warn_trip
      && !s_r.alert_mask_r[TFPGM_ST_OT_WARN_BIT]
      && !(wr_acc && wr_idx == TFPGM_CMD_ALERT_MASK) |=> !ALERT_LINE_N_O)
    else $error("OT warning did not raise alert");
  AST_WARN_STICKY: assert property (CE_I && warn_trip
      |=> s_r.stat_temp_r[TFPGM_ST_OT_WARN_BIT])
    else $error("OT warning status not set");
  // Power-good gating and sequence
  AST_PG_FAULT: assert property ((OVERCURRENT_PROTECTION_I || OV_FAULT_I || ot_trip)
      |-> !POWER_GOOD_OUTPUT_O)
    else $error("Power-good high during a fault");
  AST_OC_SS: assert property (OVERCURRENT_PROTECTION_I |-> SS_PULL_LOW_O)
    else $error("Over-current did not pull soft-start low");
  AST_PG_DROP: assert property (CE_I && s_r.pg_st_r == TFPGM_PG_GOOD && below_lower
      |=> !POWER_GOOD_OUTPUT_O)
    else $error("Power-good held below lower threshold");
  AST_PG_OFF: assert property (CE_I && !powered |=> s_r.pg_st_r == TFPGM_PG_OFF)
    else $error("Power-good sequence not reset when unpowered");
  AST_RAMP_UP: assert property (CE_I && s_r.pg_st_r == TFPGM_PG_RAMP && powered
      && !fault_any && s_r.ctrl_r[TFPGM_CTRL_PGMODE_BIT] && above_upper
      |=> s_r.pg_st_r == TFPGM_PG_GOOD)
    else $error("Power-good not reached above the upper threshold");
  AST_MODE0: assert property (CE_I && s_r.pg_st_r == TFPGM_PG_RAMP
      && !s_r.ctrl_r[TFPGM_CTRL_PGMODE_BIT] && !in_window |=> !POWER_GOOD_OUTPUT_O)
    else $error("Start-up power-good outside the 2 percent window");
  AST_WINDOW_UP: assert property (CE_I && s_r.pg_st_r == TFPGM_PG_RAMP && powered
      && !fault_any && !s_r.ctrl_r[TFPGM_CTRL_PGMODE_BIT] && in_window
      |=> s_r.pg_st_r == TFPGM_PG_GOOD)
    else $error("Power-good not reached inside the start-up window");
  // Clearing sticky status
  AST_CLEAR: assert property (CE_I && wr_acc && wr_idx == TFPGM_CMD_CLEAR_FAULTS
      && !ot_trip && !warn_trip |=> s_r.stat_temp_r == 8'h00)
    else $error("Clear-faults left temperature status set");
endmodule : tfpgm_monitor

// *** test/tfpgm_stage_model.sv ***
// Behavioural power stage: feedback slews towards a bench-set target.
// Assumes one clock; slow or prompt answers are chosen by the step input.
module tfpgm_stage_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controls from the monitor
  input wire logic convert_en_i,
  input wire logic ss_pull_low_i,
  // Bench settings
  input wire logic [15:0] target_i,
  input wire logic [15:0] step_i,
  // Feedback to the monitor
  output logic [15:0] fb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] goal;
  // Output collapses while soft-start is held low or conversion is stopped
  assign goal = (convert_en_i && !ss_pull_low_i) ? target_i : 16'h0000;
  // Slew by at most one step per cycle, like a real output capacitor
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fb_o <= 16'h0000;
    end else if (fb_o < goal) begin
      fb_o <= (goal - fb_o > step_i) ? fb_o + step_i : goal;
    end else begin
      fb_o <= (fb_o - goal > step_i) ? fb_o - step_i : goal;
    end
  end
endmodule : tfpgm_stage_model

// *** test/tfpgm_monitor_tb_top.sv ***
// Self-checking bench for the thermal fault and power-good monitor.
// Assumes the stage model drives feedback; clock enable is dropped once.
module tfpgm_monitor_tb_top
  import tfpgm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic en = 1'b0;
  logic vcc = 1'b0;
  logic oc = 1'b0;
  logic ov = 1'b0;
  logic aot = 1'b0;
  logic ce = 1'b1;
  logic [15:0] temp = 16'h0019;
  logic [15:0] target = 16'h0000;
  logic [15:0] step = 16'h0004;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] fb;
  logic pready, pslverr, pg, ss, conv, alert_n, e;
  int failures = 0;
  int check_count = 0;
  logic [7:0] codes [8] = '{TFPGM_CMD_OPERATION, TFPGM_CMD_ON_OFF_CONFIG, TFPGM_CMD_ALERT_MASK,
    TFPGM_CMD_VOUT_COMMAND, TFPGM_CMD_OT_FAULT_LIMIT, TFPGM_CMD_OT_WARN_LIMIT,
    TFPGM_CMD_POWER_GOOD_ON, TFPGM_CMD_MON_CTRL};
  logic [15:0] rstv [8] = '{16'h0080, 16'h0014, 16'h0000, 16'h019A, 16'h007D, 16'h0069,
    16'h0168, 16'h0001};
  logic [15:0] req [5] = '{16'd790, 16'd851, 16'd898, 16'd951, 16'd960};
  logic [15:0] pct [5] = '{16'd80, 16'd85, 16'd90, 16'd95, 16'd80};

  // Clock
  always #10 clk = ~clk;

  // Design and power stage
  tfpgm_monitor u_tfpgm_monitor (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .EN_I(en), .VCC_OK_I(vcc), .OVERCURRENT_PROTECTION_I(oc), .OV_FAULT_I(ov),
    .ANALOG_OT_I(aot), .FEEDBACK_SENSE_PIN_I(fb), .TEMP_I(temp),
    .POWER_GOOD_OUTPUT_O(pg), .SS_PULL_LOW_O(ss), .CONVERT_EN_O(conv),
    .ALERT_LINE_N_O(alert_n));
  tfpgm_stage_model u_tfpgm_stage_model (.clk_i(clk), .rst_i(rst), .convert_en_i(conv),
    .ss_pull_low_i(ss), .target_i(target), .step_i(step), .fb_o(fb));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      failures++;
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic [7:0] code, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, code, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Let settled values be sampled away from the rising edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold

  // Wait a bounded time for power good to reach a level
  task automatic wait_pg(input logic exp, input int lim);
    int n;
    n = 0;
    while (pg !== exp && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("power_good", pg, exp);
  endtask : wait_pg

  // Heat the die, cool it again, and check conversion in both phases
  task automatic ot_probe(input logic [15:0] t, input logic exp);
    @(posedge clk);
    temp <= t;
    hold(3);
    chk("convert_hot", conv, exp);
    @(posedge clk);
    temp <= 16'd25;
    hold(3);
    chk("convert_cool", conv, exp);
  endtask : ot_probe

  // Move the feedback target at a rising edge
  task automatic set_fb(input logic [15:0] v);
    @(posedge clk);
    target <= v;
  endtask : set_fb

  // Verdict
  task automatic conclude();
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Watchdog against a hung handshake or wait
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    conclude();
  end

  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    vcc <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(codes[i], 1'b0, 32'h0);
      chk("reset_value", rd, {16'h0000, rstv[i]});
    end
    apb(8'hD4, 1'b0, 32'h0);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    apb(TFPGM_CMD_READ_TEMP, 1'b0, 32'h0);
    chk("read_temp", rd, 32'd25);
    // Default threshold 90 % of 410, hysteresis down to 85 %, slow ramp
    set_fb(16'd369);
    hold(150);
    chk("pg_at_upper", pg, 1'b0);
    set_fb(16'd370);
    wait_pg(1'b1, 20);
    set_fb(16'd349);
    hold(10);
    chk("pg_in_hyst", pg, 1'b1);
    set_fb(16'd348);
    wait_pg(1'b0, 20);
    set_fb(16'd370);
    wait_pg(1'b1, 20);
    @(posedge clk);
    vcc <= 1'b0;
    wait_pg(1'b0, 5);
    @(posedge clk);
    vcc <= 1'b1;
    step <= 16'hFFFF;
    wait_pg(1'b1, 300);
    // Over-current and over-voltage faults
    @(posedge clk);
    oc <= 1'b1;
    @(negedge clk);
    chk("pg_on_oc", pg, 1'b0);
    chk("ss_on_oc", ss, 1'b1);
    @(posedge clk);
    oc <= 1'b0;
    ov <= 1'b1;
    @(negedge clk);
    chk("pg_on_ov", pg, 1'b0);
    apb(TFPGM_CMD_STATUS_BYTE, 1'b0, 32'h0);
    chk("status_oc_ov", rd[5:4], 2'b11);
    apb(TFPGM_CMD_STATUS_WORD, 1'b0, 32'h0);
    chk("status_pg_n", rd[11], 1'b1);
    ov <= 1'b0;
    apb(TFPGM_CMD_CLEAR_FAULTS, 1'b1, 32'h0);
    apb(TFPGM_CMD_STATUS_BYTE, 1'b0, 32'h0);
    chk("status_cleared", rd[5:4], 2'b00);
    wait_pg(1'b1, 50);
    // Clock enable low freezes state: a warning crossing is not recorded
    @(posedge clk);
    ce <= 1'b0;
    temp <= 16'd110;
    hold(3);
    chk("alert_frozen", alert_n, 1'b1);
    chk("pready_frozen", pready, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    temp <= 16'd25;
    hold(2);
    chk("alert_after_freeze", alert_n, 1'b1);
    // Warning limit, alert mask and sticky clearing
    @(posedge clk);
    temp <= 16'd110;
    hold(3);
    chk("alert_warn", alert_n, 1'b0);
    chk("convert_warn", conv, 1'b1);
    apb(TFPGM_CMD_STATUS_TEMP, 1'b0, 32'h0);
    chk("status_warn", rd[7:6], 2'b01);
    apb(TFPGM_CMD_ALERT_MASK, 1'b1, 32'h40);
    temp <= 16'd25;
    hold(2);
    chk("alert_masked", alert_n, 1'b1);
    apb(TFPGM_CMD_ALERT_MASK, 1'b1, 32'h0);
    hold(2);
    chk("alert_sticky", alert_n, 1'b0);
    apb(TFPGM_CMD_CLEAR_FAULTS, 1'b1, 32'h0);
    hold(2);
    chk("alert_cleared", alert_n, 1'b1);
    // Fault responses, recovery paths and digital versus analog trip
    ot_probe(16'd130, 1'b1);
    apb(TFPGM_CMD_MON_CTRL, 1'b1, 32'h3);
    ot_probe(16'd130, 1'b0);
    apb(TFPGM_CMD_OPERATION, 1'b1, 32'h80);
    hold(2);
    chk("convert_op", conv, 1'b1);
    ot_probe(16'd130, 1'b0);
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    hold(2);
    chk("convert_en", conv, 1'b1);
    apb(TFPGM_CMD_OT_FAULT_LIMIT, 1'b1, 32'd144);
    ot_probe(16'd145, 1'b0);
    apb(TFPGM_CMD_OPERATION, 1'b1, 32'h80);
    apb(TFPGM_CMD_OT_FAULT_LIMIT, 1'b1, 32'd150);
    ot_probe(16'd148, 1'b1);
    @(posedge clk);
    aot <= 1'b1;
    hold(3);
    @(posedge clk);
    aot <= 1'b0;
    hold(3);
    chk("convert_analog", conv, 1'b0);
    apb(TFPGM_CMD_OPERATION, 1'b1, 32'h80);
    apb(TFPGM_CMD_CLEAR_FAULTS, 1'b1, 32'h0);
    // Threshold bins against a 1000-count setpoint
    apb(TFPGM_CMD_MON_CTRL, 1'b1, 32'h1);
    apb(TFPGM_CMD_VOUT_COMMAND, 1'b1, 32'd1000);
    for (int i = 0; i < 5; i++) begin
      apb(TFPGM_CMD_POWER_GOOD_ON, 1'b1, {16'h0000, req[i]});
      set_fb(16'd0);
      wait_pg(1'b0, 20);
      set_fb(pct[i] * 16'd10);
      hold(5);
      chk("pg_bin_edge", pg, 1'b0);
      set_fb(pct[i] * 16'd10 + 16'd1);
      wait_pg(1'b1, 20);
      set_fb((pct[i] - 16'd5) * 16'd10);
      hold(5);
      chk("pg_low_edge", pg, 1'b1);
      set_fb((pct[i] - 16'd5) * 16'd10 - 16'd1);
      wait_pg(1'b0, 20);
    end
    // Start-up window mode, then normal operation
    apb(TFPGM_CMD_MON_CTRL, 1'b1, 32'h0);
    @(posedge clk);
    en <= 1'b0;
    target <= 16'd950;
    hold(3);
    @(posedge clk);
    en <= 1'b1;
    hold(20);
    chk("pg_mode0_95", pg, 1'b0);
    set_fb(16'd980);
    wait_pg(1'b1, 20);
    set_fb(16'd850);
    hold(5);
    chk("pg_mode0_hyst", pg, 1'b1);
    set_fb(16'd849);
    wait_pg(1'b0, 20);
    conclude();
  end
endmodule : tfpgm_monitor_tb_top
